// file: verification/spa_host_model.sv
// Host controller model: issues instructions and resolves the data bus.
`timescale 1ns/100ps
`default_nettype none
module spa_host_model (
    input wire logic sys_clk,
    input wire logic dq_oe,
    input wire logic [71:0] dq_out,
    output logic command_valid,
    output logic [8:0] cmd,
    output logic [71:0] dq_in
);
    import spa_pkg::*;
    logic drive = 1'b0;
    logic [71:0] host_dq = '0;
    logic [71:0] loose = 72'h5555_5555_5555_5555_55;
    // A released bus toggles so that a stale value can never look valid.
    always @(posedge sys_clk) loose <= ~loose;
    assign dq_in = drive ? host_dq : (dq_oe === 1'b1 ? dq_out : loose);
    initial begin
        command_valid = 1'b0;
        cmd = '0;
    end
    // Returns as cycle 3 begins, so a following write may start right after cycle 3.
    task automatic issue(input logic [1:0] op, input logic [4:0] dev,
        input logic [2:0] hi, input logic [15:0] lo);
        @(posedge sys_clk);
        command_valid <= 1'b1;
        cmd <= {hi, 4'h0, op};
        drive <= 1'b1;
        host_dq <= {46'h0, dev, SPA_DQ_SRAM_SEL, 3'h0, lo};
        @(posedge sys_clk);
        cmd <= {~hi, 4'h0, op};
        @(posedge sys_clk);
        command_valid <= 1'b0;
        drive <= (op != SPA_CMD_READ);
        host_dq <= ~host_dq;
        @(posedge sys_clk);
        host_dq <= ~host_dq;
    endtask
endmodule
`default_nettype wire

// file: verification/test_sram_pio_access_port.sv
// Self-checking bench for the SRAM programmed-access port.
`timescale 1ns/100ps
`default_nettype none
module test_sram_pio_access_port;
    import spa_pkg::*;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic clk_en = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, command_valid, dq_oe, ack_out, ack_oe, err;
    logic [8:0] cmd;
    logic [71:0] dq_in, dq_out;
    logic [4:0] pos = 5'h13;
    spa_sram_type sbus, strobe_bus;
    int n_fail = 0;
    int checked = 0;
    int k = 0, strobe_k = 0, ack_k = 0, ao_k = 0, dq_k = 0, n_strobe = 0;
    logic prev_cv = 1'b0, prev_ao = 1'b0, prev_dq = 1'b0;

    initial forever #5 sys_clk = ~sys_clk;

    spa_access_port #(.DQ_WIDTH(72)) DUT (.sys_clk(sys_clk),
        .arst_n(arst_n), .clk_en(clk_en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .command_valid(command_valid),
        .cmd(cmd), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
        .cascade_position_code(pos), .ack_out(ack_out), .ack_oe(ack_oe),
        .sram_address_bus(sbus));
    spa_host_model HOST (.sys_clk(sys_clk), .dq_oe(dq_oe), .dq_out(dq_out),
        .command_valid(command_valid), .cmd(cmd), .dq_in(dq_in));

    // The cycle number k restarts at 2 after each second instruction cycle.
    always @(posedge sys_clk) begin
        prev_cv <= command_valid;
        k <= (command_valid && prev_cv) ? 2 : k + 1;
        prev_ao <= ack_oe;
        prev_dq <= dq_oe;
        if (sbus.strobe_oe) begin
            strobe_k <= k;
            strobe_bus <= sbus;
            n_strobe <= n_strobe + 1;
        end
        if (ack_oe && ack_out) ack_k <= k;
        if (ack_oe && !prev_ao) ao_k <= k;
        if (dq_oe && !prev_dq) dq_k <= k;
    end

    task automatic chk(input string what, input logic [31:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a,
        input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic run(input logic [1:0] op, input logic [1:0] ts,
        input logic [2:0] hl);
        int a, h, n0;
        a = 5 + ts;
        h = a + hl + (ts == 2'h2 ? 2 : 0);
        apb(1'b1, SPA_OFS_CONFIG, {27'h0, hl, ts});
        n0 = n_strobe;
        ack_k = 0;
        ao_k = 0;
        dq_k = 0;
        HOST.issue(op, pos, 3'h5, 16'hA5C3 ^ ts);
        repeat (h + 4) @(posedge sys_clk);
        chk("strobe count", n_strobe - n0, 1);
        chk("strobe cycle", strobe_k, a);
        chk("address", strobe_bus.addr, {3'h5, pos, 16'hA5C3 ^ ts});
        chk("write strobe", strobe_bus.we_l, op == SPA_CMD_READ);
        chk("strobes", {strobe_bus.ce_l, strobe_bus.ale_l,
            strobe_bus.addr_oe}, 1);
        if (op == SPA_CMD_READ) begin
            chk("data drive", dq_k, 4);
            chk("ack high", ack_k, h);
            chk("ack drive", ao_k, h - 1);
            chk("data out", |dq_out, 0);
        end else begin
            chk("no data drive", dq_k, 0);
            chk("no ack", ao_k, 0);
        end
    endtask

    task automatic print_verdict;
        if (n_fail == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge sys_clk);
        n_fail++;
        print_verdict;
    end

    initial begin
        repeat (16) @(posedge sys_clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        apb(1'b0, SPA_OFS_STATUS, 32'h0);
        chk("status idle", rd, 0);
        chk("status error", err, 0);
        apb(1'b0, SPA_OFS_CONFIG, 32'h0);
        chk("config reset", rd, {27'h0, SPA_RST_HIT_LATENCY,
            SPA_RST_TABLE_SIZE});
        apb(1'b1, SPA_OFS_CONFIG, 32'h0000007F);
        apb(1'b0, SPA_OFS_CONFIG, 32'h0);
        chk("config", rd, 32'h0000007F);
        chk("config error", err, 0);
        apb(1'b1, SPA_OFS_STATUS, 32'h0000001F);
        chk("status write error", err, 1);
        apb(1'b0, 12'h100, 32'h0);
        chk("unmapped data", rd, 0);
        chk("unmapped error", err, 1);
        for (int ts = 0; ts < 3; ts++) begin
            run(SPA_CMD_READ, ts[1:0], ts[2:0]);
            run(SPA_CMD_WRITE, ts[1:0], 3'h3);
        end
        dq_k = 0;
        ao_k = 0;
        HOST.issue(SPA_CMD_READ, pos ^ 5'h01, 3'h1, 16'h0001);
        repeat (20) @(posedge sys_clk);
        chk("foreign strobes", n_strobe, 6);
        chk("foreign data drive", dq_k, 0);
        chk("foreign ack", ao_k, 0);
        apb(1'b1, SPA_OFS_CONFIG, 32'h0);
        HOST.issue(SPA_CMD_WRITE, pos, 3'h2, 16'h1234);
        // Three frozen edges, from the end of cycle 3, push the strobe three cycles.
        clk_en <= 1'b0;
        repeat (3) @(posedge sys_clk);
        clk_en <= 1'b1;
        repeat (10) @(posedge sys_clk);
        chk("frozen strobes", n_strobe, 7);
        chk("frozen cycle", strobe_k, SPA_ADDR_CYC_ONE + 3);
        // The widest table keeps the first write busy when the next lands.
        apb(1'b1, SPA_OFS_CONFIG, 32'h00000002);
        HOST.issue(SPA_CMD_WRITE, pos, 3'h2, 16'h1234);
        HOST.issue(SPA_CMD_WRITE, pos, 3'h3, 16'hFFFF);
        repeat (12) @(posedge sys_clk);
        chk("pipelined strobes", n_strobe, 9);
        chk("second address", strobe_bus.addr, {3'h3, pos, 16'hFFFF});
        chk("second cycle", strobe_k, SPA_ADDR_CYC_FULL);
        print_verdict;
    end
endmodule
`default_nettype wire

// file: verilog/spa_access_port.sv
// SRAM programmed-access port of a cascadable search device, APB configured.
`timescale 1ns/100ps
`default_nettype none

// Operation
// - Only the device whose position code equals data bits 25:21 acts.
// - 31-device table drives data from cycle 4 to 7, read cycle 7.
// - 31-device table: acknowledge low 8, high 9, low 10, released.
// - Write cycle appears after search latency counted from cycle 1B.
// - Data presented in write cycles 2 and 3 is ignored.
// - Writes are pipelined; next instruction may follow after cycle 3.
// - Table size 00 one device, 01 up to eight, 10 up to 31.
// - Acknowledge follows address latency plus programmed hit latency, plus two for a 31-device table.
// - Address is command bits 8:6, position code, host address 15:0.
// - Read cycle drives address, enable and latch low, write high.
module spa_access_port #(
    parameter int DQ_WIDTH = 72
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic command_valid,
    input wire logic [8:0] cmd,
    input wire logic [DQ_WIDTH-1:0] dq_in,
    output logic [DQ_WIDTH-1:0] dq_out,
    output logic dq_oe,
    input wire logic [4:0] cascade_position_code,
    output logic ack_out,
    output logic ack_oe,
    output spa_pkg::spa_sram_type sram_address_bus
);
    import spa_pkg::*;

    function automatic logic [4:0] addr_cycle(input logic [1:0] ts);
        case (ts)
            SPA_TS_ONE: addr_cycle = SPA_ADDR_CYC_ONE;
            SPA_TS_EIGHT: addr_cycle = SPA_ADDR_CYC_EIGHT;
            default: addr_cycle = SPA_ADDR_CYC_FULL;
        endcase
    endfunction

    logic rst_s1, rst_n;
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_s1 <= 1'b0;
            rst_n <= 1'b0;
        end else if (clk_en) begin
            rst_s1 <= 1'b1;
            rst_n <= rst_s1;
        end
    end

    // Pins are sampled twice; the decode below sees cycle 1B in cycle 3,
    // so a registered output chosen then first shows in cycle 4.
    logic [40:0] pin_s1, pin_s2;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1 <= '0;
            pin_s2 <= '0;
        end else if (clk_en) begin
            pin_s1 <= {command_valid, cmd, dq_in[25:0], cascade_position_code};
            pin_s2 <= pin_s1;
        end
    end

    wire s_valid = pin_s2[40];
    wire [8:0] s_cmd = pin_s2[39:31];
    wire [25:0] s_dq = pin_s2[30:5];
    wire [4:0] s_pos = pin_s2[4:0];

    logic [1:0] table_size_field;
    logic [2:0] hit_latency_field;
    logic last_sram_driver_flag, last_device_flag;
    logic first_ok;
    logic [1:0] first_code;
    logic [18:0] first_addr;
    spa_op_type op;
    logic [4:0] cyc;
    logic [23:0] inst_addr;

    wire is_rd_code = s_cmd[1:0] == SPA_CMD_READ;
    wire is_wr_code = s_cmd[1:0] == SPA_CMD_WRITE;
    wire pos_match = s_dq[25:21] == s_pos;
    wire match = s_valid && (is_rd_code || is_wr_code) &&
        s_dq[20:19] == SPA_DQ_SRAM_SEL && pos_match;
    // A read in flight blocks new decodes; a write does not.
    wire read_busy = op == SPA_OP_READ;
    wire detect = match && first_ok && first_code == s_cmd[1:0] &&
        !read_busy;
    wire [4:0] cur_addr_cyc = addr_cycle(table_size_field);
    wire [4:0] ack_extra = table_size_field == SPA_TS_ONE ||
        table_size_field == SPA_TS_EIGHT ? 5'h00 : SPA_ACK_EXTRA_FULL;
    wire [4:0] ack_hi_cyc = 5'(cur_addr_cyc + {2'b00, hit_latency_field}
        + ack_extra);
    wire done = (op == SPA_OP_READ && cyc >= 5'(ack_hi_cyc + 5'h01)) ||
        (op == SPA_OP_WRITE && cyc >= cur_addr_cyc);
    wire spa_op_type next_op = detect ? (is_rd_code ? SPA_OP_READ :
        SPA_OP_WRITE) : (done ? SPA_OP_IDLE : op);
    wire [4:0] next_cyc = detect ? SPA_FIRST_CYC :
        (op == SPA_OP_IDLE ? cyc : 5'(cyc + 5'h01));
    wire [23:0] next_inst_addr = detect ?
        {first_addr[18:16], s_pos, first_addr[15:0]} : inst_addr;
    wire next_rd = next_op == SPA_OP_READ;
    wire next_strobe = next_op != SPA_OP_IDLE && next_cyc == cur_addr_cyc;
    wire next_dq_oe = next_rd && next_cyc <= cur_addr_cyc;
    wire next_ack_oe = next_rd && next_cyc >= 5'(ack_hi_cyc - 5'h01) &&
        next_cyc <= 5'(ack_hi_cyc + 5'h01);
    wire next_ack = next_rd && next_cyc == ack_hi_cyc;
    // A read keeps write enable high; only a write pulls it low.
    wire spa_sram_type next_sram = next_strobe ? spa_sram_type'{
        next_inst_addr, 1'b1, 1'b0, 1'b0, next_rd, 1'b1} :
        SPA_SRAM_IDLE;

    // The address of 1A is kept; in a write, cycles 2 and 3 clear the
    // capture so their data can never start a second access.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            first_ok <= 1'b0;
            first_code <= 2'h0;
            first_addr <= '0;
        end else if (clk_en) begin
            first_ok <= match && !detect;
            first_code <= s_cmd[1:0];
            first_addr <= {s_cmd[8:6], s_dq[15:0]};
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            op <= SPA_OP_IDLE;
            cyc <= 5'h00;
            inst_addr <= '0;
            dq_oe <= 1'b0;
            ack_oe <= 1'b0;
            ack_out <= 1'b0;
            sram_address_bus <= SPA_SRAM_IDLE;
        end else if (clk_en) begin
            op <= next_op;
            cyc <= next_cyc;
            inst_addr <= next_inst_addr;
            dq_oe <= next_dq_oe;
            ack_oe <= next_ack_oe;
            ack_out <= next_ack;
            sram_address_bus <= next_sram;
        end
    end

    // Read data come from the SRAM straight to the host; the device only
    // holds the bus so no other party fights it.
    assign dq_out = '0;

    wire apb_setup = psel && !penable;
    wire apb_done = psel && penable && pready;
    wire hit_cfg = paddr == SPA_OFS_CONFIG;
    wire hit_sts = paddr == SPA_OFS_STATUS;
    wire [31:0] cfg_word = {25'h0000000, last_device_flag,
        last_sram_driver_flag, hit_latency_field, table_size_field};
    wire [31:0] sts_word = {24'h000000, cyc, op, dq_oe};
    wire [31:0] next_prdata = hit_cfg ? cfg_word :
        (hit_sts ? sts_word : 32'h00000000);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else if (clk_en) begin
            pready <= apb_setup;
            pslverr <= apb_setup && !hit_cfg && !(hit_sts && !pwrite);
            prdata <= apb_setup && !pwrite ? next_prdata : 32'h00000000;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            table_size_field <= SPA_RST_TABLE_SIZE;
            hit_latency_field <= SPA_RST_HIT_LATENCY;
            last_sram_driver_flag <= 1'b0;
            last_device_flag <= 1'b0;
        end else if (clk_en && apb_done && pwrite && hit_cfg) begin
            table_size_field <= pwdata[SPA_CFG_TS_LSB +: 2];
            hit_latency_field <= pwdata[SPA_CFG_HL_LSB +: 3];
            last_sram_driver_flag <= pwdata[SPA_CFG_LAST_SRAM_BIT];
            last_device_flag <= pwdata[SPA_CFG_LAST_DEV_BIT];
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n || !clk_en);

    // A start only counts on an enabled edge, so a frozen stretch never
    // opens a timing check that the held state would then break.
    wire rd_go = detect && is_rd_code && clk_en;
    wire wr_go = detect && is_wr_code && clk_en;
    wire ts_full = table_size_field == SPA_TS_FULL;
    wire strobe_on = sram_address_bus.strobe_oe;
    wire we_low = strobe_on && !sram_address_bus.we_l;

    property p_dq_window;
        rd_go && ts_full |=> dq_oe [*4] ##1 !dq_oe;
    endproperty
    a_dq_window: assert property (p_dq_window)
        else $error("bad dq drive");

    property p_ack_full;
        rd_go && ts_full && hit_latency_field == 3'h0 |-> ##5
            (ack_oe && !ack_out) ##1 ack_out ##1 (ack_oe && !ack_out)
            ##1 !ack_oe;
    endproperty
    a_ack_full: assert property (p_ack_full) else $error("bad ack");

    property p_write_latency;
        wr_go && table_size_field == SPA_TS_ONE |-> ##2 we_low;
    endproperty
    a_write_latency: assert property (p_write_latency)
        else $error("write cycle late");

    property p_size_eight;
        wr_go && table_size_field == SPA_TS_EIGHT |-> !we_low [*3] ##1 we_low;
    endproperty
    a_size_eight: assert property (p_size_eight)
        else $error("size timing wrong");

    property p_hit_latency;
        rd_go && table_size_field == SPA_TS_ONE && hit_latency_field == 3'h1
            |-> !ack_out [*3] ##1 ack_out;
    endproperty
    a_hit_latency: assert property (p_hit_latency)
        else $error("hit latency wrong");

    property p_read_strobe;
        strobe_on && op == SPA_OP_READ |-> !sram_address_bus.ce_l &&
            !sram_address_bus.ale_l && sram_address_bus.we_l && dq_oe
            ##1 !strobe_on;
    endproperty
    a_read_strobe: assert property (p_read_strobe)
        else $error("read strobe wrong");

    property p_write_pulse;
        $rose(we_low) |-> !sram_address_bus.ce_l && !dq_oe ##1 !we_low;
    endproperty
    a_write_pulse: assert property (p_write_pulse)
        else $error("write pulse wrong");

    property p_address_form;
        rd_go |-> ##[1:17] (strobe_on &&
            sram_address_bus.addr[20:16] == $past(s_pos, 1));
    endproperty
    a_address_form: assert property (p_address_form)
        else $error("address wrong");

    property p_pipelined;
        op == SPA_OP_WRITE && match && first_ok &&
            first_code == s_cmd[1:0] |=> cyc == SPA_FIRST_CYC;
    endproperty
    a_pipelined: assert property (p_pipelined)
        else $error("write blocked");

    property p_only_selected;
        $rose(dq_oe) |-> $past(pos_match, 1);
    endproperty
    a_only_selected: assert property (p_only_selected)
        else $error("unselected drive");

    c_read_full: cover property (rd_go && ts_full);
    c_write_one: cover property (wr_go && table_size_field == SPA_TS_ONE);
    c_back_write: cover property (wr_go ##[1:8] wr_go);
    c_ack_pulse: cover property ($rose(ack_out));
endmodule

`default_nettype wire

// file: verilog/spa_pkg.sv
// Shared constants and types for the SRAM programmed-access port.
package spa_pkg;
    // Instruction codes on the two low command lines and the SRAM select code on data bits 20:19; the values are arbitrary.
    localparam logic [1:0] SPA_CMD_READ = 2'h1;
    localparam logic [1:0] SPA_CMD_WRITE = 2'h2;
    localparam logic [1:0] SPA_DQ_SRAM_SEL = 2'h2;
    // Table-size settings.
    localparam logic [1:0] SPA_TS_ONE = 2'h0;
    localparam logic [1:0] SPA_TS_EIGHT = 2'h1;
    localparam logic [1:0] SPA_TS_FULL = 2'h2;
    // Cycle numbers of an access, counted with 1B as cycle 1, and the extra acknowledge cycles of a 31-device table.
    localparam logic [4:0] SPA_FIRST_CYC = 5'h04;
    localparam logic [4:0] SPA_ADDR_CYC_ONE = 5'h05;
    localparam logic [4:0] SPA_ADDR_CYC_EIGHT = 5'h06;
    localparam logic [4:0] SPA_ADDR_CYC_FULL = 5'h07;
    localparam logic [4:0] SPA_ACK_EXTRA_FULL = 5'h02;
    // Register offsets and reset values.
    localparam logic [11:0] SPA_OFS_CONFIG = 12'h000;
    localparam logic [11:0] SPA_OFS_STATUS = 12'h004;
    localparam logic [1:0] SPA_RST_TABLE_SIZE = 2'h0;
    localparam logic [2:0] SPA_RST_HIT_LATENCY = 3'h0;
    // Config field positions.
    localparam int SPA_CFG_TS_LSB = 0;
    localparam int SPA_CFG_HL_LSB = 2;
    localparam int SPA_CFG_LAST_SRAM_BIT = 5;
    localparam int SPA_CFG_LAST_DEV_BIT = 6;

    typedef enum logic [1:0] {
        SPA_OP_IDLE = 2'b00,
        SPA_OP_READ = 2'b01,
        SPA_OP_WRITE = 2'b10
    } spa_op_type;

    typedef struct packed {
        logic [23:0] addr;
        logic addr_oe;
        logic ce_l;
        logic ale_l;
        logic we_l;
        logic strobe_oe;
    } spa_sram_type;

    localparam spa_sram_type SPA_SRAM_IDLE = '{24'h000000, 1'b0, 1'b1,
        1'b1, 1'b1, 1'b0};
endpackage
